// ==== include/eep_pkg.sv ====
// shared constants and types for the two-wire serial eeprom target
// assumes a 50 MHz system clock sampling both bus lines
package eep_pkg;

  localparam int CLK_HZ       = 50_000_000;
  localparam int PROG_TIME_MS = 5;
  localparam int PROG_CYCLES  = PROG_TIME_MS * (CLK_HZ / 1000);
  // clocks from a stop on the pins until the program count starts
  localparam int STOP_LAT     = 3;

  localparam int ADDR_W       = 15;
  localparam int MEM_BYTES    = 32768;
  localparam int PAGE_W       = 6;
  localparam int FIFO_DEPTH   = 4;

  localparam logic [3:0] DEV_CODE = 4'ha;
  localparam logic [3:0] BIT_ACK  = 4'h8;
  localparam logic [3:0] BIT_END  = 4'h9;

  typedef enum {
    ST_IDLE,
    ST_DEV,
    ST_WADDR_HI,
    ST_WADDR_LO,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } eep_state_e;

  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       wp;
    logic [2:0] sel;
  } eep_pins_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } eep_wr_s;

endpackage

// ==== rtl/eep_sync.sv ====
// two-flop synchroniser for a group of asynchronous pins
// assumes nothing reads the first stage
`timescale 1ns/10ps
module eep_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_reg <= RST_VAL;
      q_reg    <= RST_VAL;
    end
    else
    begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule

// ==== rtl/eep_fifo.sv ====
// small flop fifo with valid/ready on both sides
// assumes both sides on the same clock
`timescale 1ns/10ps
module eep_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0]   count_reg;
  logic          push;
  logic          pop;

  assign in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      if (pop)
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data;
  end

endmodule

// ==== rtl/eep_target.sv ====
// two-wire serial eeprom target: protocol engine, address counter, array
// assumes scl and sda arrive asynchronously and are sampled by clk
//
// Contract
// - sda change while scl high marks start/stop
// - sda fall with scl high starts transaction
// - sda rise with scl high stops, standby
// - device acknowledges each received byte low
// - standby at power-up and after stop
// - device word opens with fixed 1010 code
// - three select bits must match strapped pins
// - match acks; mismatch no ack, standby
// - eighth bit: one reads, zero writes
// - write-protect high blocks all array writes
// - two word-address bytes then data, each acked
// - stop starts 5 ms program cycle, deaf
// - page write takes up to 64 bytes
// - write address wraps within the page
// - polling acked only after program cycle ends
// - counter holds last address plus one
// - read address wraps from top to zero
// - current read sends byte at counter
// - sequential read continues while controller acks
// - sample on scl rise, change on fall
// - fifteen address bits, 512 pages of 64
// - write-protect low allows normal operation
`timescale 1ns/10ps
module eep_target #(
  parameter int PROG_CYC   = eep_pkg::PROG_CYCLES,
  parameter int FIFO_DEPTH = eep_pkg::FIFO_DEPTH
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic select_pin_high,
  input  wire logic select_pin_mid,
  input  wire logic select_pin_low,
  input  wire logic write_protect,
  output logic      standby,
  output logic      prog_busy
);
  import eep_pkg::*;

  localparam int PCW = $clog2(PROG_CYC + 1);
  localparam int WRW = $bits(eep_wr_s);

  eep_pins_s         pins_raw;
  eep_pins_s         pins_s;
  logic              scl_d_reg;
  logic              sda_d_reg;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_det;
  logic              stop_det;
  eep_state_e        st_reg;
  logic [3:0]        cnt_reg;
  logic [7:0]        rx_reg;
  logic [7:0]        tx_reg;
  logic [6:0]        addr_hi_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              mst_ack_reg;
  logic              wrote_reg;
  logic              sda_oe_reg;
  logic              sda_out_reg;
  logic              standby_reg;
  logic              busy_reg;
  logic [PCW-1:0]    prog_cnt_reg;
  logic              dev_match;
  logic              ack;
  logic              byte_done;
  logic              ack_end;
  logic              rd_load;
  logic              push;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  eep_wr_s           wr_in;
  eep_wr_s           wr_out;
  logic [7:0]        mem [MEM_BYTES];

  // address arithmetic
  function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
    page_inc = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 1'b1};
  endfunction

  function automatic logic [ADDR_W-1:0] seq_inc(input logic [ADDR_W-1:0] a);
    seq_inc = a + 1'b1;
  endfunction

  assign pins_raw.scl = scl_in;
  assign pins_raw.sda = sda_in;
  assign pins_raw.wp  = write_protect;
  assign pins_raw.sel = {select_pin_high, select_pin_mid, select_pin_low};

  // bus lines reset to their idle high level so no false edge follows reset
  eep_sync #(
    .W       (6),
    .RST_VAL (6'h30)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (pins_raw),
    .q       (pins_s)
  );

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= pins_s.scl;
      sda_d_reg <= pins_s.sda;
    end
  end

  assign scl_rise  = pins_s.scl & ~scl_d_reg;
  assign scl_fall  = ~pins_s.scl & scl_d_reg;
  assign start_det = pins_s.scl & scl_d_reg & sda_d_reg & ~pins_s.sda;
  assign stop_det  = pins_s.scl & scl_d_reg & ~sda_d_reg & pins_s.sda;

  assign byte_done = scl_fall && (cnt_reg == BIT_ACK);
  assign ack_end   = scl_fall && (cnt_reg == BIT_END);
  assign dev_match = (rx_reg[7:1] == {DEV_CODE, pins_s.sel});
  assign rd_load   = ack_end && (st_reg == ST_RDATA) && mst_ack_reg;

  // acknowledge decision for the byte just received
  always_comb
  begin
    case (st_reg)
      ST_DEV:      ack = dev_match & ~busy_reg;
      ST_WADDR_HI: ack = 1'b1;
      ST_WADDR_LO: ack = 1'b1;
      ST_WDATA:    ack = ~pins_s.wp & fifo_in_ready;
      default:     ack = 1'b0;
    endcase
  end

  assign push = byte_done && (st_reg == ST_WDATA) && ack;

  // bit counter: rises count bits, fall after ninth clock ends the word
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_reg <= 4'h0;
    else if (start_det || stop_det)
      cnt_reg <= 4'h0;
    else if (scl_rise && cnt_reg != BIT_END)
      cnt_reg <= cnt_reg + 4'h1;
    else if (ack_end)
      cnt_reg <= 4'h0;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rx_reg <= 8'h00;
    else if (scl_rise && cnt_reg < BIT_ACK)
      rx_reg <= {rx_reg[6:0], pins_s.sda};
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      mst_ack_reg <= 1'b0;
    else if (byte_done && st_reg == ST_DEV)
      mst_ack_reg <= 1'b1;
    else if (scl_rise && st_reg == ST_RDATA && cnt_reg == BIT_ACK)
      mst_ack_reg <= ~pins_s.sda;
  end

  // protocol state
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_reg <= ST_IDLE;
    else if (start_det)
      st_reg <= ST_DEV;
    else if (stop_det)
      st_reg <= ST_IDLE;
    else if (byte_done)
    begin
      case (st_reg)
        ST_DEV:
        begin
          if (!ack)
            st_reg <= ST_IDLE;
          else if (rx_reg[0])
            st_reg <= ST_RDATA;
          else
            st_reg <= ST_WADDR_HI;
        end
        ST_WADDR_HI: st_reg <= ST_WADDR_LO;
        ST_WADDR_LO: st_reg <= ST_WDATA;
        default:     st_reg <= st_reg;
      endcase
    end
    else if (ack_end && st_reg == ST_RDATA && !mst_ack_reg)
      st_reg <= ST_IGNORE;
  end

  // address counter
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      addr_hi_reg <= 7'h00;
      addr_reg    <= '0;
    end
    else if (byte_done && st_reg == ST_WADDR_HI)
      addr_hi_reg <= rx_reg[6:0];
    else if (byte_done && st_reg == ST_WADDR_LO)
      addr_reg <= {addr_hi_reg, rx_reg};
    else if (push)
      addr_reg <= page_inc(addr_reg);
    else if (rd_load)
      addr_reg <= seq_inc(addr_reg);
  end

  // transmit shifter
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      tx_reg <= 8'h00;
    else if (rd_load)
      tx_reg <= mem[addr_reg];
    else if (scl_fall && st_reg == ST_RDATA && cnt_reg < BIT_ACK)
      tx_reg <= {tx_reg[6:0], 1'b0};
  end

  // open-drain data drive, changed on scl falls and released at start or stop
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sda_oe_reg <= 1'b0;
    else if (start_det || stop_det)
      sda_oe_reg <= 1'b0;
    else if (byte_done)
      sda_oe_reg <= (st_reg != ST_RDATA) & ack;
    else if (rd_load)
      sda_oe_reg <= ~mem[addr_reg][7];
    else if (ack_end)
      sda_oe_reg <= 1'b0;
    else if (scl_fall && st_reg == ST_RDATA && cnt_reg < BIT_ACK)
      sda_oe_reg <= ~tx_reg[6];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sda_out_reg <= 1'b0;
    else
      sda_out_reg <= 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wrote_reg <= 1'b0;
    else if (push)
      wrote_reg <= 1'b1;
    else if (start_det || stop_det)
      wrote_reg <= 1'b0;
  end

  // self-timed program cycle from the stop of a write
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy_reg     <= 1'b0;
      prog_cnt_reg <= '0;
    end
    else if (busy_reg)
    begin
      if (prog_cnt_reg == PCW'(PROG_CYC - 1))
        busy_reg <= 1'b0;
      prog_cnt_reg <= prog_cnt_reg + 1'b1;
    end
    else if (stop_det && st_reg == ST_WDATA && wrote_reg)
    begin
      busy_reg     <= 1'b1;
      // detection latency counts into the cycle, which ends by PROG_CYC after the pin stop
      prog_cnt_reg <= PCW'(STOP_LAT);
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      standby_reg <= 1'b1;
    else
      standby_reg <= (st_reg == ST_IDLE) & ~busy_reg;
  end

  // write data path through the buffer into the array
  assign wr_in.addr     = addr_reg;
  assign wr_in.data     = rx_reg;
  // array has one port; a read load takes precedence
  assign fifo_out_ready = ~rd_load;

  eep_fifo #(
    .W     (WRW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (wr_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (wr_out)
  );

  always_ff @(posedge clk)
  begin
    if (fifo_out_valid && fifo_out_ready)
      mem[wr_out.addr] <= wr_out.data;
  end

  assign sda_out   = sda_out_reg;
  assign sda_oe    = sda_oe_reg;
  assign standby   = standby_reg;
  assign prog_busy = busy_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  start_resets_a: assert property (
    start_det |=> (st_reg == ST_DEV) && (cnt_reg == 4'h0) && !sda_oe_reg)
    else $error("start did not restart the word");

  stop_idles_a: assert property (
    stop_det |=> (st_reg == ST_IDLE) && !sda_oe_reg)
    else $error("stop did not return to idle");

  drive_on_low_a: assert property (
    $rose(sda_oe_reg) |-> !pins_s.scl)
    else $error("data drive changed while scl high");

  byte_acked_a: assert property (
    (byte_done && (st_reg == ST_WADDR_HI || st_reg == ST_WADDR_LO)) |=> sda_oe_reg)
    else $error("address byte not acknowledged");

  mismatch_nack_a: assert property (
    (byte_done && st_reg == ST_DEV && !dev_match) |=> !sda_oe_reg && st_reg == ST_IDLE)
    else $error("foreign device word was acknowledged");

  busy_deaf_a: assert property (
    (byte_done && st_reg == ST_DEV && busy_reg) |=> !sda_oe_reg)
    else $error("device answered during program cycle");

  prog_start_a: assert property (
    (stop_det && st_reg == ST_WDATA && wrote_reg && !busy_reg)
      |=> busy_reg [*8])
    else $error("program cycle did not start on stop");

  prog_length_a: assert property (
    $fell(busy_reg) |-> $past(prog_cnt_reg) == PCW'(PROG_CYC - 1))
    else $error("program cycle length wrong");

  wp_blocks_a: assert property (
    pins_s.wp |-> !push)
    else $error("write accepted under write protect");

  page_wrap_a: assert property (
    push |=> addr_reg[ADDR_W-1:PAGE_W] == $past(addr_reg[ADDR_W-1:PAGE_W]))
    else $error("write address left its page");

  read_inc_a: assert property (
    rd_load |=> addr_reg == seq_inc($past(addr_reg)))
    else $error("read address did not advance");

endmodule

// ==== testbench/eep_ctrl_model.sv ====
// bus controller model: drives the serial clock and pulls the data line low
// assumes a pull-up on the data line, resolved by the bench
`timescale 1ns/10ps
module eep_ctrl_model #(
  parameter int HALF_NS = 400
) (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  localparam int Q = HALF_NS / 2;

  // clock stands high and data is released while the bus is idle
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // entered from idle or with the clock low, so it serves as repeated start
  task automatic start();
    #(Q) sda_low = 1'b0;
    #(HALF_NS - Q) scl = 1'b1;
    #(Q) sda_low = 1'b1;
    #(HALF_NS - Q) scl = 1'b0;
  endtask

  task automatic stop();
    #(Q) sda_low = 1'b1;
    #(HALF_NS - Q) scl = 1'b1;
    #(Q) sda_low = 1'b0;
    #(HALF_NS - Q);
  endtask

  // data moves only mid-low; sampled just before the clock falls
  task automatic clk_bit(input logic b, output logic r);
    #(Q) sda_low = ~b;
    #(HALF_NS - Q) scl = 1'b1;
    #(HALF_NS - 2) r = sda;
    #2 scl = 1'b0;
  endtask

  // eight bits msb first, then the ninth bit driven with last
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(d[i], r);
      q[i] = r;
    end
    clk_bit(last, r);
    ack = ~r;
  endtask

  task automatic recover();
    logic r;
    start();
    for (int i = 0; i < 9; i++)
      clk_bit(1'b1, r);
    start();
    stop();
  endtask
endmodule

// ==== testbench/two_wire_serial_eeprom_target_tb.sv ====
// self-checking bench for the two-wire eeprom target
// assumes the controller model and a pull-up on the data line
`timescale 1ns/10ps
module two_wire_serial_eeprom_target_tb;
  import eep_pkg::*;

  localparam int PROG_CYC = 2000;

  logic        clk;
  logic        sys_rst;
  logic        scl;
  logic        sda_low;
  wire logic   sda;
  logic        sda_out;
  logic        sda_oe;
  logic [2:0]  sel;
  logic        wp;
  logic        standby;
  logic        prog_busy;
  logic [7:0]  ref_mem [int];
  logic [14:0] cur;
  logic [31:0] seed;
  int          n_errors;
  int          n_tests;

  assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;

  eep_ctrl_model #(.HALF_NS(80)) ctrl_u (.scl(scl), .sda_low(sda_low), .sda(sda));

  eep_target #(.PROG_CYC(PROG_CYC), .FIFO_DEPTH(4)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .select_pin_high(sel[2]), .select_pin_mid(sel[1]),
    .select_pin_low(sel[0]), .write_protect(wp), .standby(standby),
    .prog_busy(prog_busy));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic test_done();
    if (n_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic dev(input logic [3:0] code, input logic [2:0] s, input logic rw,
                     input logic exp_ack);
    logic [7:0] q;
    logic       ack;
    ctrl_u.start();
    ctrl_u.xfer({code, s, rw}, 1'b1, q, ack);
    check(ack, exp_ack);
  endtask

  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic [7:0] q;
    logic       ack;
    ctrl_u.xfer(d, 1'b1, q, ack);
    check(ack, exp_ack);
  endtask

  task automatic set_addr(input logic [14:0] a);
    dev(DEV_CODE, sel, 1'b0, 1'b1);
    seed = lfsr(seed);
    send({seed[0], a[14:8]}, 1'b1);
    send(a[7:0], 1'b1);
  endtask

  // entered just after the stop; busy may not outlast PROG_CYC clocks from it
  task automatic wait_prog(input logic busy_exp);
    realtime t0;
    int      k;
    t0 = $realtime;
    repeat (10) @(posedge clk);
    check(prog_busy, busy_exp);
    if (busy_exp)
    begin
      dev(DEV_CODE, sel, 1'b0, 1'b0);
      ctrl_u.stop();
      k = 0;
      while (prog_busy !== 1'b0 && k < 2 * PROG_CYC)
      begin
        @(posedge clk);
        #1;
        k++;
      end
      check(16'(k < 2 * PROG_CYC), 16'h1);
      check(16'(int'(($realtime - t0) / 20.0) <= PROG_CYC), 16'h1);
    end
    repeat (2) @(posedge clk);
    check(standby, 1'b1);
    dev(DEV_CODE, sel, 1'b0, 1'b1);
    ctrl_u.stop();
  endtask

  task automatic write_at(input logic [14:0] a, input int n);
    set_addr(a);
    cur = a;
    for (int i = 0; i < n; i++)
    begin
      seed = lfsr(seed);
      send(seed[7:0], ~wp);
      if (!wp)
        ref_mem[cur] = seed[7:0];
      cur = {cur[14:6], cur[5:0] + 6'h1};
    end
    ctrl_u.stop();
    wait_prog(n > 0 && !wp);
  endtask

  // reads from the counter, expected at a; controller nacks the last byte
  task automatic read_run(input logic [14:0] a, input int n);
    logic [7:0] q;
    logic       ack;
    dev(DEV_CODE, sel, 1'b1, 1'b1);
    check(standby, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      ctrl_u.xfer(8'hff, i == n - 1, q, ack);
      check(q, ref_mem[a]);
      a = a + 15'h1;
    end
    cur = a;
    ctrl_u.stop();
    repeat (6) @(posedge clk);
    check(standby, 1'b1);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    #1_500_000;
    n_errors++;
    $display("[FAIL] %0t run timed out", $time);
    test_done();
  end

  initial
  begin
    logic        b;
    logic [14:0] base;
    sys_rst  = 1'b1;
    sel      = 3'h0;
    wp       = 1'b0;
    seed     = 32'hda75;
    n_errors = 0;
    n_tests  = 0;
    cur      = 15'h0;
    repeat (3) @(posedge clk);
    check({standby, prog_busy, sda_oe}, 16'h4);
    #1 sys_rst = 1'b0;
    seed = lfsr(seed);
    sel  = seed[2:0];
    repeat (6) @(posedge clk);
    // wrong select bit each in turn, then a wrong fixed code
    for (int k = 0; k < 4; k++)
    begin
      dev(k == 3 ? 4'h5 : DEV_CODE, k == 3 ? sel : sel ^ 3'(1 << k), 1'b0, 1'b0);
      ctrl_u.stop();
    end
    // page write across the page end
    seed = lfsr(seed);
    base = {seed[14:6], 6'h0};
    write_at(base + 15'd62, 6);
    set_addr(base);
    read_run(base, 3);
    read_run(cur, 1);
    set_addr(base + 15'd62);
    read_run(base + 15'd62, 2);
    // read counter rolls from the top address to zero
    write_at(15'h7fff, 1);
    write_at(15'h0000, 1);
    set_addr(15'h7fff);
    read_run(15'h7fff, 2);
    // protected write leaves the array untouched
    @(posedge clk);
    #1 wp = 1'b1;
    write_at(base, 1);
    @(posedge clk);
    #1 wp = 1'b0;
    set_addr(base);
    read_run(base, 1);
    // abort mid-byte, recover, then the device answers again
    dev(DEV_CODE, sel, 1'b0, 1'b1);
    send(8'h00, 1'b1);
    for (int i = 0; i < 3; i++)
      ctrl_u.clk_bit(1'b0, b);
    ctrl_u.recover();
    dev(DEV_CODE, sel, 1'b0, 1'b1);
    ctrl_u.stop();
    for (int k = 0; k < 2; k++)
    begin
      seed = lfsr(seed);
      @(posedge clk);
      #1 sel = seed[2:0];
      repeat (4) @(posedge clk);
      base = {seed[14:6], 1'b0, seed[20:16]};
      write_at(base, 1 + int'(seed[24:23]));
      set_addr(base);
      read_run(base, 1 + int'(seed[24:23]));
    end
    test_done();
  end
endmodule
